// ### scl_top.sv
// The register addresses and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
module scl_top #(
   parameter int PERIOD_CYC = scl_pkg::PERIOD_CYC,
   parameter int BLANK_CYC  = scl_pkg::BLANK_CYC
) (
   // Clock and reset
   input  wire logic                   clk,
   input  wire logic                   resetn,
   // Strap level codes
   input  wire scl_pkg::scl_lvl_t      addr_hi_warn_strap,
   input  wire scl_pkg::scl_lvl_t      addr_mid_strap,
   input  wire scl_pkg::scl_lvl_t      addr_low_strap,
   input  wire scl_pkg::scl_lvl_t      copper_iface_strap,
   input  wire logic                   single_speed_strap,
   // Link status
   input  wire logic                   fiber_link_up,
   input  wire logic                   copper_link_up,
   // Decoded configuration
   output logic [4:0]                  mgmt_addr,
   output logic                        cfg_valid,
   output logic                        copper_iface_sel,
   output logic                        short_copper_reach,
   output logic                        low_copper_drive,
   output logic                        scrambler_en,
   output logic                        eq_bypass,
   // Transmitter enables
   output logic                        fiber_tx_en,
   output logic                        copper_tx_en,
   // Register port
   input  wire logic [scl_pkg::AW-1:0] reg_addr,
   input  wire logic [scl_pkg::DW-1:0] reg_wdata,
   input  wire logic                   reg_wr,
   input  wire logic                   reg_rd,
   output logic [scl_pkg::DW-1:0]      reg_rdata
);

   // ----------------------------------------------------------------
   // Reset release
   // ----------------------------------------------------------------
   logic [1:0] rst_sync_ff;
   logic       rst_n;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rst_sync_ff <= 2'h0;
      end else begin
         rst_sync_ff <= {rst_sync_ff[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_ff[1];

   // ----------------------------------------------------------------
   // Strap sampling
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {S_WAIT, S_LOAD, S_RUN} scl_state_e;

   scl_state_e          state_ff, nxt_state;
   logic [15:0]         dly_ff, nxt_dly;
   scl_pkg::scl_straps_s straps_in;
   scl_pkg::scl_dec_s   dec;

   assign straps_in = '{hi: addr_hi_warn_strap, mid: addr_mid_strap,
                        low: addr_low_strap, copper: copper_iface_strap};

   scl_strap_dec u_dec (
      .straps (straps_in),
      .dec    (dec)
   );

   always_comb begin
      nxt_state = state_ff;
      nxt_dly   = dly_ff;
      case (state_ff)
         S_WAIT: begin
            nxt_dly = dly_ff + 16'h1;
            if (dly_ff == 16'(scl_pkg::SAMPLE_CYC - 1)) begin
               nxt_state = S_LOAD;
            end
         end
         S_LOAD: begin
            nxt_state = S_RUN;
         end
         S_RUN: begin
            nxt_state = S_RUN;
         end
         default: begin
            nxt_state = S_WAIT;
            nxt_dly   = '0;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_ff <= S_WAIT;
         dly_ff   <= '0;
      end else begin
         state_ff <= nxt_state;
         dly_ff   <= nxt_dly;
      end
   end

   // ----------------------------------------------------------------
   // Configuration registers
   // ----------------------------------------------------------------
   logic [4:0]  addr_ff, nxt_addr;
   logic        iface_ff, nxt_iface;
   logic        short_ff, nxt_short;
   logic        low_ff, nxt_low;
   logic        scdis_ff, nxt_scdis;
   logic        single_ff, nxt_single;
   logic        warn_ff, nxt_warn;
   logic        valid_ff, nxt_valid;
   logic        load;
   logic        wr_copper;
   logic        wr_speed;

   assign load      = (state_ff == S_LOAD);
   assign wr_copper = reg_wr && (reg_addr == scl_pkg::REG_COPPER);
   assign wr_speed  = reg_wr && (reg_addr == scl_pkg::REG_SPEED);

   always_comb begin
      nxt_addr   = addr_ff;
      nxt_iface  = iface_ff;
      nxt_short  = short_ff;
      nxt_low    = low_ff;
      nxt_scdis  = scdis_ff;
      nxt_single = single_ff;
      nxt_warn   = warn_ff;
      nxt_valid  = valid_ff;
      if (load) begin
         nxt_addr   = dec.addr;
         nxt_iface  = dec.iface_sel;
         nxt_short  = dec.short_reach;
         nxt_low    = dec.low_drive;
         nxt_scdis  = 1'b0;
         nxt_single = single_speed_strap;
         nxt_warn   = dec.warn_en;
         nxt_valid  = 1'b1;
      end else begin
         if (wr_copper) begin
            nxt_iface = reg_wdata[scl_pkg::CP_IFACE];
            nxt_short = reg_wdata[scl_pkg::CP_SHORT];
            nxt_low   = reg_wdata[scl_pkg::CP_LOW];
            nxt_scdis = reg_wdata[scl_pkg::CP_SCDIS];
         end
         if (wr_speed) begin
            nxt_single = reg_wdata[scl_pkg::SP_SINGLE];
            nxt_warn   = reg_wdata[scl_pkg::SP_WARN];
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         addr_ff   <= '0;
         iface_ff  <= 1'b0;
         short_ff  <= 1'b0;
         low_ff    <= 1'b0;
         scdis_ff  <= 1'b0;
         single_ff <= 1'b0;
         warn_ff   <= 1'b0;
         valid_ff  <= 1'b0;
      end else begin
         addr_ff   <= nxt_addr;
         iface_ff  <= nxt_iface;
         short_ff  <= nxt_short;
         low_ff    <= nxt_low;
         scdis_ff  <= nxt_scdis;
         single_ff <= nxt_single;
         warn_ff   <= nxt_warn;
         valid_ff  <= nxt_valid;
      end
   end

   assign mgmt_addr          = addr_ff;
   assign cfg_valid          = valid_ff;
   assign copper_iface_sel   = iface_ff;
   assign short_copper_reach = short_ff;
   assign low_copper_drive   = low_ff;
   assign scrambler_en       = !iface_ff && !scdis_ff;
   assign eq_bypass          = !iface_ff && short_ff && !low_ff;

   // ----------------------------------------------------------------
   // Link integrity warning
   // ----------------------------------------------------------------
   logic warn_act;
   logic blank;
   logic f_down;
   logic c_down;
   logic ftx_ff, nxt_ftx;
   logic ctx_ff, nxt_ctx;

   assign warn_act = valid_ff && warn_ff && single_ff;
   assign f_down   = !fiber_link_up;
   assign c_down   = !copper_link_up;

   scl_blank_timer #(
      .PERIOD (PERIOD_CYC),
      .BLANK  (BLANK_CYC)
   ) u_timer (
      .clk   (clk),
      .rst_n (rst_n),
      .run   (warn_act),
      .blank (blank)
   );

   // Same gating for both ports, applied only while single rate is selected
   always_comb begin
      nxt_ftx = 1'b1;
      nxt_ctx = 1'b1;
      if (warn_act) begin
         if (f_down && c_down) begin
            nxt_ftx = 1'b0;
            nxt_ctx = 1'b0;
         end else begin
            nxt_ftx = !(f_down && blank);
            nxt_ctx = !(c_down && blank);
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ftx_ff <= 1'b1;
         ctx_ff <= 1'b1;
      end else begin
         ftx_ff <= nxt_ftx;
         ctx_ff <= nxt_ctx;
      end
   end

   assign fiber_tx_en  = ftx_ff;
   assign copper_tx_en = ctx_ff;

   // ----------------------------------------------------------------
   // Register read
   // ----------------------------------------------------------------
   logic [scl_pkg::DW-1:0] rdata_ff, nxt_rdata;

   always_comb begin
      nxt_rdata = '0;
      if (reg_rd) begin
         case (reg_addr)
            scl_pkg::REG_COPPER: begin
               nxt_rdata[scl_pkg::CP_IFACE] = iface_ff;
               nxt_rdata[scl_pkg::CP_SHORT] = short_ff;
               nxt_rdata[scl_pkg::CP_LOW]   = low_ff;
               nxt_rdata[scl_pkg::CP_SCDIS] = scdis_ff;
            end
            scl_pkg::REG_SPEED: begin
               nxt_rdata[scl_pkg::SP_SINGLE] = single_ff;
               nxt_rdata[scl_pkg::SP_WARN]   = warn_ff;
            end
            scl_pkg::REG_STATUS: begin
               nxt_rdata[scl_pkg::ST_ADDR +: 5] = addr_ff;
               nxt_rdata[scl_pkg::ST_VALID]     = valid_ff;
               nxt_rdata[scl_pkg::ST_FBLANK]    = !ftx_ff;
               nxt_rdata[scl_pkg::ST_CBLANK]    = !ctx_ff;
               nxt_rdata[scl_pkg::ST_WACT]      = warn_act;
            end
            default: begin
               nxt_rdata = '0;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_ff <= '0;
      end else begin
         rdata_ff <= nxt_rdata;
      end
   end

   assign reg_rdata = rdata_ff;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   cfg_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
      cfg_valid && !wr_copper |=> $stable(short_copper_reach))
      else $error("copper default changed without a write");

   sequence load_seq;
      state_ff == S_LOAD;
   endsequence

   addr_hi_dec_a: assert property (@(posedge clk) disable iff (!rst_n)
      load_seq |=> mgmt_addr[4] == $past(addr_hi_warn_strap[1]) &&
      warn_ff == ($past(addr_hi_warn_strap) == scl_pkg::LVL_THIRD ||
      $past(addr_hi_warn_strap) == scl_pkg::LVL_TWO3))
      else $error("high strap decode wrong");

   addr_mid_dec_a: assert property (@(posedge clk) disable iff (!rst_n)
      load_seq ##0 (addr_mid_strap == scl_pkg::LVL_THIRD) |=>
      mgmt_addr[3:2] == 2'h2)
      else $error("middle strap decode wrong");

   addr_low_dec_a: assert property (@(posedge clk) disable iff (!rst_n)
      load_seq ##0 (addr_low_strap == scl_pkg::LVL_VCC) |=>
      mgmt_addr[1:0] == 2'h1)
      else $error("low strap decode wrong");

   warn_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
      !single_ff ##1 !single_ff |-> fiber_tx_en && copper_tx_en)
      else $error("warning active without single rate");

   fiber_blank_a: assert property (@(posedge clk) disable iff (!rst_n)
      warn_act && blank && f_down && !c_down |=> !fiber_tx_en &&
      copper_tx_en)
      else $error("fiber transmitter not blanked");

   copper_blank_a: assert property (@(posedge clk) disable iff (!rst_n)
      warn_act && blank && c_down && !f_down |=> !copper_tx_en &&
      fiber_tx_en)
      else $error("copper transmitter not blanked");

   both_down_a: assert property (@(posedge clk) disable iff (!rst_n)
      warn_act && f_down && c_down |=> !fiber_tx_en && !copper_tx_en)
      else $error("output while both links down");

   copper_dec_a: assert property (@(posedge clk) disable iff (!rst_n)
      load_seq ##0 (copper_iface_strap == scl_pkg::LVL_TWO3) |=>
      !copper_iface_sel && short_copper_reach && low_copper_drive)
      else $error("copper strap decode wrong");

   scram_def_a: assert property (@(posedge clk) disable iff (!rst_n)
      load_seq ##0 (copper_iface_strap != scl_pkg::LVL_THIRD) |=>
      scrambler_en)
      else $error("scrambler not enabled by default");

   eq_bypass_a: assert property (@(posedge clk) disable iff (!rst_n)
      load_seq ##0 (copper_iface_strap == scl_pkg::LVL_VCC) |=> eq_bypass)
      else $error("equalizer not bypassed for short reach");

   addr_held_a: assert property (@(posedge clk) disable iff (!rst_n)
      cfg_valid |=> cfg_valid && $stable(mgmt_addr))
      else $error("address changed after sampling");

   reg_write_a: assert property (@(posedge clk) disable iff (!rst_n)
      wr_copper && !load |=> copper_iface_sel == $past(reg_wdata[0]) &&
      low_copper_drive == $past(reg_wdata[2]))
      else $error("strap default not overwritten");

endmodule

// ### scl_pkg.sv
package scl_pkg;

   // ----------------------------------------------------------------
   // Strap levels
   // ----------------------------------------------------------------
   typedef logic [1:0] scl_lvl_t;
   localparam scl_lvl_t LVL_GND   = 2'h0;
   localparam scl_lvl_t LVL_THIRD = 2'h1;
   localparam scl_lvl_t LVL_TWO3  = 2'h2;
   localparam scl_lvl_t LVL_VCC   = 2'h3;

   typedef struct packed {
      scl_lvl_t hi;
      scl_lvl_t mid;
      scl_lvl_t low;
      scl_lvl_t copper;
   } scl_straps_s;

   typedef struct packed {
      logic       warn_en;
      logic [4:0] addr;
      logic       iface_sel;
      logic       short_reach;
      logic       low_drive;
   } scl_dec_s;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int    CLK_PERIOD_PS = 8000;
   localparam int    SAMPLE_DLY_NS = 2000;
   localparam int    SAMPLE_CYC    = (SAMPLE_DLY_NS * 1000 + CLK_PERIOD_PS
                                      - 1) / CLK_PERIOD_PS;
   localparam longint BLANK_MS     = 425;
   localparam longint PERIOD_MS    = 3800;
   localparam int    BLANK_CYC     = int'(BLANK_MS * 64'd1000000000
                                      / CLK_PERIOD_PS);
   localparam int    PERIOD_CYC    = int'(PERIOD_MS * 64'd1000000000
                                      / CLK_PERIOD_PS);

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam int         AW          = 8;
   localparam int         DW          = 16;
   localparam logic [7:0] REG_COPPER  = 8'h00;
   localparam logic [7:0] REG_SPEED   = 8'h04;
   localparam logic [7:0] REG_STATUS  = 8'h08;
   localparam int CP_IFACE = 0;
   localparam int CP_SHORT = 1;
   localparam int CP_LOW   = 2;
   localparam int CP_SCDIS = 3;
   localparam int SP_SINGLE = 0;
   localparam int SP_WARN   = 1;
   localparam int ST_ADDR   = 0;
   localparam int ST_VALID  = 5;
   localparam int ST_FBLANK = 6;
   localparam int ST_CBLANK = 7;
   localparam int ST_WACT   = 8;

   // ----------------------------------------------------------------
   // Two-bit address pair from a level
   // ----------------------------------------------------------------
   function automatic logic [1:0] pair_dec(scl_lvl_t lvl);
      case (lvl)
         LVL_GND:   pair_dec = 2'h0;
         LVL_THIRD: pair_dec = 2'h2;
         LVL_TWO3:  pair_dec = 2'h3;
         default:   pair_dec = 2'h1;
      endcase
   endfunction

endpackage

// ### scl_strap_dec.sv
`timescale 1ns/1ps
module scl_strap_dec (
   // Level codes
   input  scl_pkg::scl_straps_s straps,
   // Decoded defaults
   output scl_pkg::scl_dec_s    dec
);

   always_comb begin
      dec = '0;
      dec.warn_en = (straps.hi == scl_pkg::LVL_THIRD) ||
                    (straps.hi == scl_pkg::LVL_TWO3);
      dec.addr[4] = straps.hi[1];
      dec.addr[3:2] = scl_pkg::pair_dec(straps.mid);
      dec.addr[1:0] = scl_pkg::pair_dec(straps.low);
      case (straps.copper)
         scl_pkg::LVL_GND: begin
            dec.iface_sel   = 1'b0;
            dec.short_reach = 1'b0;
            dec.low_drive   = 1'b0;
         end
         scl_pkg::LVL_THIRD: begin
            dec.iface_sel   = 1'b1;
            dec.short_reach = 1'b0;
            dec.low_drive   = 1'b0;
         end
         scl_pkg::LVL_TWO3: begin
            dec.iface_sel   = 1'b0;
            dec.short_reach = 1'b1;
            dec.low_drive   = 1'b1;
         end
         default: begin
            dec.iface_sel   = 1'b0;
            dec.short_reach = 1'b1;
            dec.low_drive   = 1'b0;
         end
      endcase
   end

endmodule

// ### scl_blank_timer.sv
`timescale 1ns/1ps
module scl_blank_timer #(
   parameter int PERIOD = scl_pkg::PERIOD_CYC,
   parameter int BLANK  = scl_pkg::BLANK_CYC
) (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // Control
   input  wire logic run,
   output logic      blank
);

   logic [31:0] cnt_ff;
   logic [31:0] nxt_cnt;

   // Period counter that runs only while warning is active, restarted whenever warning stops
   always_comb begin
      nxt_cnt = '0;
      if (run && (cnt_ff != 32'(PERIOD - 1))) begin
         nxt_cnt = cnt_ff + 32'h1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_ff <= '0;
      end else begin
         cnt_ff <= nxt_cnt;
      end
   end

   assign blank = run && (cnt_ff < 32'(BLANK));

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   period_wrap_a: assert property (@(posedge clk) disable iff (!rst_n)
      run && cnt_ff == 32'(PERIOD - 1) |=> cnt_ff == 32'h0 &&
      blank == run)
      else $error("blank period did not wrap");

endmodule

// ### scl_board.sv
`timescale 1ns/1ps
module scl_board (
   // Clock
   input  wire logic        clk,
   // Strap level codes
   output scl_pkg::scl_lvl_t addr_hi_warn_strap,
   output scl_pkg::scl_lvl_t addr_mid_strap,
   output scl_pkg::scl_lvl_t addr_low_strap,
   output scl_pkg::scl_lvl_t copper_iface_strap,
   output logic              single_speed_strap,
   // Remote link state
   output logic              fiber_link_up,
   output logic              copper_link_up
);
   initial begin
      addr_hi_warn_strap = scl_pkg::LVL_GND;
      addr_mid_strap     = scl_pkg::LVL_GND;
      addr_low_strap     = scl_pkg::LVL_GND;
      copper_iface_strap = scl_pkg::LVL_GND;
      single_speed_strap = 1'b1;
      fiber_link_up      = 1'b1;
      copper_link_up     = 1'b1;
   end

   // ----------------------------------------------------------------
   // Straps are set on the next clock edge and stay put until the next call
   // ----------------------------------------------------------------
   task automatic set_straps(input scl_pkg::scl_lvl_t h, m, l, c,
                             input logic single);
      @(posedge clk);
      addr_hi_warn_strap <= h;
      addr_mid_strap     <= m;
      addr_low_strap     <= l;
      copper_iface_strap <= c;
      single_speed_strap <= single;
   endtask

   task automatic set_links(input logic f, c);
      @(posedge clk);
      fiber_link_up  <= f;
      copper_link_up <= c;
   endtask
endmodule

// ### strap_config_link_warning_bench.sv
`timescale 1ns/1ps
module strap_config_link_warning_bench;
   localparam int P = 40;
   localparam int B = 8;
   localparam logic [1:0] PAIR [4] = '{2'h0, 2'h2, 2'h3, 2'h1};
   localparam logic       HI_W [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
   localparam logic       HI_B [4] = '{1'b0, 1'b0, 1'b1, 1'b1};
   localparam logic [2:0] CP   [4] = '{3'h0, 3'h4, 3'h3, 3'h2};

   logic                     clk;
   logic                     resetn;
   scl_pkg::scl_lvl_t        s_hi;
   scl_pkg::scl_lvl_t        s_mid;
   scl_pkg::scl_lvl_t        s_low;
   scl_pkg::scl_lvl_t        s_cu;
   logic                     s_single;
   logic                     f_up;
   logic                     c_up;
   logic [4:0]               mgmt_addr;
   logic                     cfg_valid;
   logic                     c_sel;
   logic                     c_short;
   logic                     c_low;
   logic                     scrambler_en;
   logic                     eq_bypass;
   logic                     fiber_tx_en;
   logic                     copper_tx_en;
   logic [scl_pkg::AW-1:0]   reg_addr;
   logic [scl_pkg::DW-1:0]   reg_wdata;
   logic                     reg_wr;
   logic                     reg_rd;
   logic [scl_pkg::DW-1:0]   reg_rdata;
   logic [15:0]              rd;
   logic [4:0]               ea;
   int                       n_errors;
   int                       check_count;
   int                       lf;
   int                       lc;

   scl_board u_board (
      .clk(clk), .addr_hi_warn_strap(s_hi), .addr_mid_strap(s_mid),
      .addr_low_strap(s_low), .copper_iface_strap(s_cu),
      .single_speed_strap(s_single), .fiber_link_up(f_up),
      .copper_link_up(c_up));

   scl_top #(.PERIOD_CYC(P), .BLANK_CYC(B)) u_dut (
      .clk(clk), .resetn(resetn), .addr_hi_warn_strap(s_hi),
      .addr_mid_strap(s_mid), .addr_low_strap(s_low),
      .copper_iface_strap(s_cu), .single_speed_strap(s_single),
      .fiber_link_up(f_up), .copper_link_up(c_up),
      .mgmt_addr(mgmt_addr), .cfg_valid(cfg_valid),
      .copper_iface_sel(c_sel), .short_copper_reach(c_short),
      .low_copper_drive(c_low), .scrambler_en(scrambler_en),
      .eq_bypass(eq_bypass), .fiber_tx_en(fiber_tx_en),
      .copper_tx_en(copper_tx_en), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata));

   // ----------------------------------------------------------------
   // Clock, helpers
   // ----------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task automatic chk(input logic [15:0] got, exp, input string what);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic results;
      $display("checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic do_reset;
      int k;
      k = 0;
      @(posedge clk);
      resetn <= 1'b0;
      repeat (8) @(posedge clk);
      resetn <= 1'b1;
      while (cfg_valid !== 1'b1 && k < 400) begin
         @(negedge clk);
         k++;
      end
      if (k >= 400) begin
         n_errors++;
         $display("MISMATCH t=%0t no cfg_valid", $time);
      end
      @(negedge clk);
   endtask

   task automatic reg_write(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr    <= 1'b0;
   endtask

   task automatic reg_read(input logic [7:0] a, output logic [15:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd   <= 1'b0;
      #1 d = reg_rdata;
   endtask

   // Low cycles of each transmitter enable over two blanking periods
   task automatic count_low(output int f, c);
      f = 0;
      c = 0;
      repeat (4) @(negedge clk);
      repeat (2 * P) begin
         @(negedge clk);
         if (fiber_tx_en === 1'b0) f++;
         if (copper_tx_en === 1'b0) c++;
      end
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      n_errors++;
      $display("MISMATCH t=%0t watchdog timeout", $time);
      results;
   end

   // ----------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------
   initial begin
      resetn = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 16'h0000;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      n_errors = 0;
      check_count = 0;
      for (int i = 0; i < 4; i++) begin
         u_board.set_straps(2'(i), 2'(i), 2'(i), 2'(i), 1'b1);
         do_reset;
         ea = {HI_B[i], PAIR[i], PAIR[i]};
         chk(16'(mgmt_addr), 16'(ea), "addr");
         chk(16'({c_sel, c_short, c_low}), 16'(CP[i]), "copper");
         chk(16'(scrambler_en), 16'(!CP[i][2]), "scrambler");
         chk(16'(eq_bypass), 16'(CP[i] == 3'h2), "eq bypass");
         chk(16'({fiber_tx_en, copper_tx_en}), 16'h0003, "tx on");
         reg_read(scl_pkg::REG_STATUS, rd);
         chk(rd, {7'h0, HI_W[i], 2'h0, 1'b1, ea}, "status");
      end
      $display("strap decode done");

      u_board.set_straps(2'h1, 2'h1, 2'h1, 2'h1, 1'b1);
      repeat (6) @(negedge clk);
      chk(16'(mgmt_addr), 16'h0015, "held addr");
      chk(16'({c_sel, c_short, c_low}), 16'h0002, "held copper");
      reg_write(scl_pkg::REG_COPPER, 16'h0008);
      reg_write(scl_pkg::REG_STATUS, 16'h0000);
      reg_write(8'h10, 16'hffff);
      reg_read(scl_pkg::REG_COPPER, rd);
      chk(rd, 16'h0008, "copper rw");
      chk(16'(scrambler_en), 16'h0000, "scr off");
      reg_read(scl_pkg::REG_STATUS, rd);
      chk(rd, 16'h0035, "status ro");
      reg_read(8'h0c, rd);
      chk(rd, 16'h0000, "unmapped");
      reg_write(scl_pkg::REG_COPPER, 16'h0001);
      @(negedge clk);
      chk(16'({c_sel, scrambler_en, eq_bypass}), 16'h0004, "ecl");
      reg_write(scl_pkg::REG_COPPER, 16'h0006);
      @(negedge clk);
      chk(16'({c_short, c_low, eq_bypass}), 16'h0006, "low drv");
      $display("register test done");

      u_board.set_straps(2'h2, 2'h0, 2'h0, 2'h0, 1'b0);
      do_reset;
      u_board.set_links(1'b0, 1'b1);
      count_low(lf, lc);
      chk(16'(lf), 16'h0000, "multi rate");
      reg_write(scl_pkg::REG_SPEED, 16'h0003);
      reg_read(scl_pkg::REG_SPEED, rd);
      chk(rd, 16'h0003, "speed rw");
      count_low(lf, lc);
      chk(16'(lf), 16'(2 * B), "fiber blank");
      chk(16'(lc), 16'h0000, "copper on");
      u_board.set_links(1'b1, 1'b0);
      count_low(lf, lc);
      chk(16'(lc), 16'(2 * B), "copper blank");
      chk(16'(lf), 16'h0000, "fiber on");
      u_board.set_links(1'b0, 1'b0);
      count_low(lf, lc);
      chk(16'(lf), 16'(2 * P), "both fiber");
      chk(16'(lc), 16'(2 * P), "both copper");
      reg_read(scl_pkg::REG_STATUS, rd);
      chk(rd, 16'h01f0, "both blanked");
      reg_write(scl_pkg::REG_SPEED, 16'h0001);
      count_low(lf, lc);
      chk(16'(lf + lc), 16'h0000, "warn off");
      $display("warning test done");
      results;
   end
endmodule
